// >>> src/cis_datapath.sv
// Instruction execution datapath between decoder and register file
// How it works
// - Word or byte add and subtract, optionally with carry; two or four bytes long
// - Signed or unsigned 16x16 multiply of two registers; two bytes long
// - Short divide: low muldiv half by register, signed or unsigned, 16/16
// - Long divide: full 32-bit muldiv pair by 16-bit register, signed or unsigned
// - Compare data with register, then decrement register by one or two
// - Compare data with register, then increment register by one or two
// - Count shifts needed to normalize a register, store count in another
// - Arithmetic right shift copies the sign bit into vacated upper bits
// - Rotate register left or right, bits wrap around; two bytes long
// - Widen a byte into a word with sign or zero extension
// - Complement or two's-complement negate a word or byte register
// - Update masked bits of high or low byte with immediate data
// - Copy a source bit, optionally inverted, into a destination bit
// - Combine two bits with AND, OR or XOR, result into a bit
// - Relative jump on bit set or clear; modifying forms toggle the bit only when the jump is taken
// - Push a register on the stack, then call an absolute target
// - Push a register on the stack, then load it with a word operand
// - Return to caller; popping form also restores a register from stack
// - Power down entered only while the interrupt pin is held low
`timescale 1ns/10ps
module cis_datapath (
  // Clock and reset
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_ARST_N,
  // Decoded request
  input  wire cis_pkg::cis_req_type I_REQ,
  // Non-maskable interrupt pin
  input  wire logic                 I_NMI_PIN,
  // Results
  output cis_pkg::cis_rsp_type      O_RSP,
  output logic                      O_POWER_DOWN
);
  import cis_pkg::*;

  cis_rsp_type rsp_reg;
  cis_rsp_type rsp_next;
  logic        power_down_instr_reg;
  logic [1:0]  nmi_sync_reg;
  logic        nmi_low;

  logic [15:0] a;
  logic [15:0] b;
  logic        bw;
  logic        sub_op;
  logic        cin;
  logic [16:0] sum;
  logic [15:0] res;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;
  logic [31:0] dvd;
  logic [31:0] dvs;
  logic [31:0] quo;
  logic [31:0] rem;
  logic        div_ovf;
  logic [31:0] prod;
  logic [15:0] cmp_diff;
  logic [15:0] step;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                        input logic bop, input logic hi);
    if (!bop)
      return val;
    else if (hi)
      return {val[7:0], old[7:0]};
    else
      return {old[15:8], val[7:0]};
  endfunction : merge

  function automatic logic [15:0] norm_cnt(input logic [15:0] v);
    logic [15:0] n;
    logic        hit;
    n   = '0;
    hit = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!hit) begin
        if (v[i])
          hit = 1'b1;
        else
          n = n + STEP_ONE;
      end
    end
    return hit ? n : '0;
  endfunction : norm_cnt

  // Pin synchroniser, resets to pin high so no false low
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      nmi_sync_reg <= SYNC_RST;
    else
      nmi_sync_reg <= {nmi_sync_reg[0], I_NMI_PIN};
  end
  assign nmi_low = ~nmi_sync_reg[1];

  // Shared adder, operands narrowed for byte forms
  always_comb begin
    bw     = I_REQ.byte_op;
    a      = bw ? {8'h00, I_REQ.opa[7:0]} : I_REQ.opa;
    b      = bw ? {8'h00, I_REQ.opb[7:0]} : I_REQ.opb;
    sub_op = (I_REQ.op == OP_SUB_PLAIN) || (I_REQ.op == OP_SUB_CARRY) || (I_REQ.op == OP_NEGATE);
    cin    = ((I_REQ.op == OP_ADD_CARRY) || (I_REQ.op == OP_SUB_CARRY)) & I_REQ.carry_in;
    if (I_REQ.op == OP_NEGATE) begin
      sum = 17'h00000 - {1'b0, a};
      b   = a;
      a   = 16'h0000;
    end else if (sub_op)
      sum = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
    else
      sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    res   = sum[15:0];
    msb_a = bw ? a[7] : a[15];
    msb_b = bw ? b[7] : b[15];
    msb_r = bw ? res[7] : res[15];
  end

  // Divider and multiplier
  always_comb begin
    if (I_REQ.op == OP_DIV_LONG)
      dvd = I_REQ.muldiv;
    else if (I_REQ.signed_op)
      dvd = {{16{I_REQ.muldiv[15]}}, I_REQ.muldiv[15:0]};
    else
      dvd = {16'h0000, I_REQ.muldiv[15:0]};
    dvs = I_REQ.signed_op ? {{16{I_REQ.opb[15]}}, I_REQ.opb} : {16'h0000, I_REQ.opb};
    if (I_REQ.opb == 16'h0000) begin
      quo     = '0;
      rem     = '0;
      div_ovf = 1'b1;
    end else if (I_REQ.signed_op) begin
      quo     = 32'($signed(dvd) / $signed(dvs));
      rem     = 32'($signed(dvd) % $signed(dvs));
      div_ovf = (quo[31:15] != {17{1'b0}}) && (quo[31:15] != {17{1'b1}});
    end else begin
      quo     = dvd / dvs;
      rem     = dvd % dvs;
      div_ovf = (quo[31:16] != 16'h0000);
    end
    if (I_REQ.signed_op)
      prod = $signed({{16{I_REQ.opa[15]}}, I_REQ.opa}) * $signed({{16{I_REQ.opb[15]}}, I_REQ.opb});
    else
      prod = {16'h0000, I_REQ.opa} * {16'h0000, I_REQ.opb};
    cmp_diff = I_REQ.opa - I_REQ.opb;
    step     = I_REQ.variant ? STEP_TWO : STEP_ONE;
  end

  // Result selection per operation
  always_comb begin
    rsp_next         = RSP_RESET;
    rsp_next.valid   = I_REQ.valid;
    rsp_next.dst     = I_REQ.dst_old;
    rsp_next.muldiv  = I_REQ.muldiv;
    rsp_next.jump_pc = I_REQ.pc_next;
    rsp_next.len     = I_REQ.long_form ? LEN_LONG : LEN_SHORT;
    unique case (I_REQ.op)
      OP_ADD_PLAIN, OP_ADD_CARRY, OP_SUB_PLAIN, OP_SUB_CARRY, OP_NEGATE: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = merge(I_REQ.dst_old, res, bw, I_REQ.hi_byte);
        rsp_next.c      = bw ? sum[8] : sum[16];
        rsp_next.v      = sub_op ? (msb_a != msb_b) && (msb_r != msb_a)
                                 : (msb_a == msb_b) && (msb_r != msb_a);
        rsp_next.z      = bw ? (res[7:0] == 8'h00) : (res == 16'h0000);
        rsp_next.n      = msb_r;
        if (I_REQ.op == OP_NEGATE)
          rsp_next.len = LEN_SHORT;
      end
      OP_COMPLEMENT: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = merge(I_REQ.dst_old, ~I_REQ.opa, bw, I_REQ.hi_byte);
        rsp_next.z      = bw ? (I_REQ.opa[7:0] == 8'hFF) : (I_REQ.opa == 16'hFFFF);
        rsp_next.n      = bw ? ~I_REQ.opa[7] : ~I_REQ.opa[15];
        rsp_next.len    = LEN_SHORT;
      end
      OP_MULT: begin
        rsp_next.wr_muldiv = 1'b1;
        rsp_next.muldiv    = prod;
        rsp_next.z         = (prod == 32'h00000000);
        rsp_next.n         = prod[31];
        rsp_next.len       = LEN_SHORT;
      end
      OP_DIV_SHORT, OP_DIV_LONG: begin
        rsp_next.wr_muldiv = !div_ovf;
        rsp_next.muldiv    = div_ovf ? I_REQ.muldiv : {rem[15:0], quo[15:0]};
        rsp_next.v         = div_ovf;
        rsp_next.z         = (quo[15:0] == 16'h0000);
        rsp_next.n         = quo[15];
        rsp_next.len       = LEN_SHORT;
      end
      OP_CMP_DEC, OP_CMP_INC: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = (I_REQ.op == OP_CMP_DEC) ? I_REQ.opa - step
                                                   : I_REQ.opa + step;
        rsp_next.c      = I_REQ.opa < I_REQ.opb;
        rsp_next.v      = (I_REQ.opa[15] != I_REQ.opb[15]) && (cmp_diff[15] != I_REQ.opa[15]);
        rsp_next.z      = (cmp_diff == 16'h0000);
        rsp_next.n      = cmp_diff[15];
      end
      OP_NORM: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = norm_cnt(I_REQ.opa);
        rsp_next.z      = (I_REQ.opa == 16'h0000);
        rsp_next.len    = LEN_SHORT;
      end
      OP_SHIFT_ARITH: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = 16'($signed(I_REQ.opa) >>> I_REQ.opb[3:0]);
        rsp_next.n      = I_REQ.opa[15];
        rsp_next.len    = LEN_SHORT;
      end
      OP_ROTATE: begin
        rsp_next.wr_dst = 1'b1;
        if (I_REQ.variant)
          rsp_next.dst = 16'(({I_REQ.opa, I_REQ.opa} << I_REQ.opb[3:0]) >> 16);
        else
          rsp_next.dst = 16'({I_REQ.opa, I_REQ.opa} >> I_REQ.opb[3:0]);
        rsp_next.len    = LEN_SHORT;
      end
      OP_BYTE_EXT: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = {{8{I_REQ.variant & I_REQ.opa[7]}}, I_REQ.opa[7:0]};
        rsp_next.n      = I_REQ.variant & I_REQ.opa[7];
      end
      OP_MASK_MOD: begin
        rsp_next.wr_dst = 1'b1;
        rsp_next.dst    = merge(I_REQ.dst_old, {8'h00, (I_REQ.opa[7:0] & ~I_REQ.opb[7:0])
                          | (I_REQ.opb[15:8] & I_REQ.opb[7:0])}, 1'b1, I_REQ.hi_byte);
        rsp_next.len    = LEN_LONG;
      end
      OP_BIT_COPY: begin
        rsp_next.wr_bit  = 1'b1;
        rsp_next.bit_val = I_REQ.bit_a ^ I_REQ.variant;
        rsp_next.len     = LEN_LONG;
      end
      OP_BIT_LOGIC: begin
        rsp_next.wr_bit = 1'b1;
        unique case (I_REQ.bit_op)
          BIT_AND: rsp_next.bit_val = I_REQ.bit_a & I_REQ.bit_b;
          BIT_OR:  rsp_next.bit_val = I_REQ.bit_a | I_REQ.bit_b;
          default: rsp_next.bit_val = I_REQ.bit_a ^ I_REQ.bit_b;
        endcase
        rsp_next.len = LEN_LONG;
      end
      OP_JUMP_SET, OP_JUMP_CLR: begin
        rsp_next.jump    = I_REQ.bit_a == (I_REQ.op == OP_JUMP_SET);
        rsp_next.jump_pc = I_REQ.pc_next + I_REQ.rel_off;
        rsp_next.wr_bit  = I_REQ.variant && rsp_next.jump;
        rsp_next.bit_val = (I_REQ.op == OP_JUMP_CLR);
        rsp_next.len     = LEN_LONG;
      end
      OP_PUSH_CALL: begin
        rsp_next.push_cnt = 2'h2;
        rsp_next.push0    = I_REQ.opa;
        rsp_next.push1    = I_REQ.pc_next;
        rsp_next.jump     = 1'b1;
        rsp_next.jump_pc  = I_REQ.target;
        rsp_next.len      = LEN_LONG;
      end
      OP_CTX_SWITCH: begin
        rsp_next.push_cnt = 2'h1;
        rsp_next.push0    = I_REQ.dst_old;
        rsp_next.wr_dst   = 1'b1;
        rsp_next.dst      = I_REQ.opb;
        rsp_next.len      = LEN_LONG;
      end
      OP_RETURN: begin
        rsp_next.jump    = 1'b1;
        rsp_next.jump_pc = I_REQ.stack0;
        rsp_next.pop_cnt = I_REQ.variant ? 2'h2 : 2'h1;
        rsp_next.wr_dst  = I_REQ.variant;
        rsp_next.dst     = I_REQ.variant ? I_REQ.stack1 : I_REQ.dst_old;
        rsp_next.len     = LEN_SHORT;
      end
      OP_POWER_DOWN: rsp_next.len = LEN_LONG;
      default:       rsp_next.len = LEN_SHORT;
    endcase
    if (!I_REQ.valid) begin
      rsp_next.wr_dst    = 1'b0;
      rsp_next.wr_muldiv = 1'b0;
      rsp_next.wr_bit    = 1'b0;
      rsp_next.push_cnt  = 2'h0;
      rsp_next.pop_cnt   = 2'h0;
      rsp_next.jump      = 1'b0;
    end
  end

  // Result register
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      rsp_reg <= RSP_RESET;
    else
      rsp_reg <= rsp_next;
  end

  // Power-down latch, left only by reset
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      power_down_instr_reg <= POWER_DOWN_INSTR_RST;
    else if (I_REQ.valid && I_REQ.op == OP_POWER_DOWN && nmi_low)
      power_down_instr_reg <= 1'b1;
  end

  assign O_RSP        = rsp_reg;
  assign O_POWER_DOWN = power_down_instr_reg;

  a_add_word: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_ADD_CARRY && !I_REQ.byte_op
    |=> O_RSP.dst == 16'($past(I_REQ.opa) + $past(I_REQ.opb) + {15'h0000, $past(I_REQ.carry_in)}))
    else $error("add with carry wrong");
  a_byte_keep: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.byte_op && I_REQ.hi_byte && I_REQ.op == OP_SUB_PLAIN
    |=> O_RSP.dst[7:0] == $past(I_REQ.dst_old[7:0]))
    else $error("byte form touched other byte");
  a_mult_unsigned: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_MULT && !I_REQ.signed_op
    |=> O_RSP.wr_muldiv && O_RSP.muldiv == ({16'h0000, $past(I_REQ.opa)} * {16'h0000, $past(I_REQ.opb)})
    && O_RSP.len == LEN_SHORT)
    else $error("multiply wrong");
  a_div_short: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_DIV_SHORT && !I_REQ.signed_op && I_REQ.opb != 16'h0000
    |=> O_RSP.muldiv[15:0] == $past(I_REQ.muldiv[15:0]) / $past(I_REQ.opb))
    else $error("short divide quotient wrong");
  a_div_long: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_DIV_LONG && !I_REQ.signed_op && I_REQ.opb != 16'h0000
    && I_REQ.muldiv[31:16] < I_REQ.opb
    |=> O_RSP.wr_muldiv && O_RSP.muldiv[31:16] == 16'($past(I_REQ.muldiv) % {16'h0000, $past(I_REQ.opb)}))
    else $error("long divide remainder wrong");
  a_cmp_step: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_CMP_DEC && I_REQ.variant
    |=> O_RSP.wr_dst && O_RSP.dst == $past(I_REQ.opa) - STEP_TWO)
    else $error("compare decrement wrong");
  a_cmp_inc: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_CMP_INC && !I_REQ.variant
    |=> O_RSP.dst == $past(I_REQ.opa) + STEP_ONE)
    else $error("compare increment wrong");
  a_norm_top: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_NORM && I_REQ.opa == 16'h0001 |=> O_RSP.dst == 16'h000F)
    else $error("normalize count wrong");
  a_sign_fill: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_SHIFT_ARITH && I_REQ.opa[15] |=> O_RSP.dst[15])
    else $error("sign not replicated");
  a_jump_modify: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ.valid && I_REQ.op == OP_JUMP_SET && I_REQ.variant && I_REQ.bit_a
    |=> O_RSP.jump && O_RSP.wr_bit && !O_RSP.bit_val)
    else $error("jump on set did not clear bit");
  a_power_down_instr_gate: assert property (@(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    $rose(O_POWER_DOWN) |-> !$past(nmi_sync_reg[1]) && $past(I_REQ.op) == OP_POWER_DOWN)
    else $error("power down while pin high");

endmodule : cis_datapath

// >>> src/cis_pkg.sv
// Package: operation codes, carriers and constants of the instruction datapath
package cis_pkg;

  typedef enum logic [4:0] {
    OP_NOP         = 5'h00,
    OP_ADD_PLAIN   = 5'h01,
    OP_ADD_CARRY   = 5'h02,
    OP_SUB_PLAIN   = 5'h03,
    OP_SUB_CARRY   = 5'h04,
    OP_MULT        = 5'h05,
    OP_DIV_SHORT   = 5'h06,
    OP_DIV_LONG    = 5'h07,
    OP_CMP_DEC     = 5'h08,
    OP_CMP_INC     = 5'h09,
    OP_NORM        = 5'h0A,
    OP_SHIFT_ARITH = 5'h0B,
    OP_ROTATE      = 5'h0C,
    OP_BYTE_EXT    = 5'h0D,
    OP_COMPLEMENT  = 5'h0E,
    OP_NEGATE      = 5'h0F,
    OP_MASK_MOD    = 5'h10,
    OP_BIT_COPY    = 5'h11,
    OP_BIT_LOGIC   = 5'h12,
    OP_JUMP_SET    = 5'h13,
    OP_JUMP_CLR    = 5'h14,
    OP_PUSH_CALL   = 5'h15,
    OP_CTX_SWITCH  = 5'h16,
    OP_RETURN      = 5'h17,
    OP_POWER_DOWN  = 5'h18
  } cis_op_type;

  typedef enum logic [1:0] {
    BIT_AND = 2'h0,
    BIT_OR  = 2'h1,
    BIT_XOR = 2'h2
  } cis_bitop_type;

  typedef struct packed {
    logic          valid;
    cis_op_type    op;
    logic          byte_op;
    logic          hi_byte;
    logic          long_form;
    logic          signed_op;
    logic          variant;
    cis_bitop_type bit_op;
    logic          carry_in;
    logic          bit_a;
    logic          bit_b;
    logic [15:0]   opa;
    logic [15:0]   opb;
    logic [15:0]   dst_old;
    logic [31:0]   muldiv;
    logic [15:0]   pc_next;
    logic [15:0]   rel_off;
    logic [15:0]   target;
    logic [15:0]   stack0;
    logic [15:0]   stack1;
  } cis_req_type;

  typedef struct packed {
    logic        valid;
    logic        wr_dst;
    logic [15:0] dst;
    logic        wr_aux;
    logic [15:0] aux;
    logic        wr_muldiv;
    logic [31:0] muldiv;
    logic        c;
    logic        v;
    logic        z;
    logic        n;
    logic        wr_bit;
    logic        bit_val;
    logic [1:0]  push_cnt;
    logic [15:0] push0;
    logic [15:0] push1;
    logic [1:0]  pop_cnt;
    logic        jump;
    logic [15:0] jump_pc;
    logic [2:0]  len;
  } cis_rsp_type;

  localparam logic [2:0]  LEN_SHORT  = 3'h2;
  localparam logic [2:0]  LEN_LONG   = 3'h4;
  localparam logic [15:0] STEP_ONE   = 16'h0001;
  localparam logic [15:0] STEP_TWO   = 16'h0002;
  localparam cis_rsp_type RSP_RESET  = '0;
  localparam logic        POWER_DOWN_INSTR_RST  = 1'b0;
  localparam logic [1:0]  SYNC_RST   = 2'h3;

endpackage : cis_pkg

// >>> tb/cis_tb.sv
// Self-checking testbench of the instruction datapath
`timescale 1ns/10ps
module tb;
  import cis_pkg::*;
  logic        I_SYS_CLK;
  logic        I_ARST_N;
  cis_req_type I_REQ;
  logic        I_NMI_PIN;
  cis_rsp_type O_RSP;
  logic        O_POWER_DOWN;
  cis_rsp_type rsp;
  cis_req_type r;
  int          fails;
  int          tests_run;
  int          k;

  cis_datapath dut_u (
    .I_SYS_CLK    (I_SYS_CLK),
    .I_ARST_N     (I_ARST_N),
    .I_REQ        (I_REQ),
    .I_NMI_PIN    (I_NMI_PIN),
    .O_RSP        (O_RSP),
    .O_POWER_DOWN (O_POWER_DOWN)
  );

  initial I_SYS_CLK = 1'b0;
  always #2.5 I_SYS_CLK = ~I_SYS_CLK;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  function automatic cis_req_type mk(input cis_op_type op, input logic [15:0] a, input logic [15:0] b,
                                     input logic vr);
    cis_req_type q;
    q         = '0;
    q.valid   = 1'b1;
    q.op      = op;
    q.opa     = a;
    q.opb     = b;
    q.variant = vr;
    return q;
  endfunction : mk

  // Drive at the falling edge, take the answer at the next falling edge
  task automatic run(input cis_req_type q);
    I_REQ = q;
    @(posedge I_SYS_CLK);
    @(negedge I_SYS_CLK);
    rsp = O_RSP;
  endtask : run

  task automatic t_addsub;
    run(mk(OP_ADD_PLAIN, 16'h1234, 16'h0FFF, 1'b0));
    chk("add dst", 32'h0000_2233, 32'(rsp.dst));
    chk("add len", 32'(LEN_SHORT), 32'(rsp.len));
    r           = mk(OP_ADD_PLAIN, 16'h0001, 16'h0002, 1'b0);
    r.long_form = 1'b1;
    run(r);
    chk("add long len", 32'(LEN_LONG), 32'(rsp.len));
    r          = mk(OP_ADD_CARRY, 16'h0001, 16'h0002, 1'b0);
    r.carry_in = 1'b1;
    run(r);
    chk("addc dst", 32'h0000_0004, 32'(rsp.dst));
    run(mk(OP_SUB_PLAIN, 16'h0005, 16'h0002, 1'b0));
    chk("sub dst", 32'h0000_0003, 32'(rsp.dst));
    r          = mk(OP_SUB_CARRY, 16'h0005, 16'h0002, 1'b0);
    r.carry_in = 1'b1;
    run(r);
    chk("subc dst", 32'h0000_0002, 32'(rsp.dst));
    r         = mk(OP_ADD_PLAIN, 16'h00F0, 16'h0020, 1'b0);
    r.byte_op = 1'b1;
    r.hi_byte = 1'b1;
    r.dst_old = 16'hABCD;
    run(r);
    chk("add byte dst", 32'h0000_10CD, 32'(rsp.dst));
    r.op  = OP_SUB_PLAIN;
    r.opa = 16'h0010;
    r.opb = 16'h0001;
    run(r);
    chk("sub byte dst", 32'h0000_0FCD, 32'(rsp.dst));
    $display("test addsub done");
  endtask : t_addsub

  task automatic t_muldiv;
    run(mk(OP_MULT, 16'hFFFF, 16'h0002, 1'b0));
    chk("mulu", 32'h0001_FFFE, rsp.muldiv);
    chk("mulu len", 32'(LEN_SHORT), 32'(rsp.len));
    r           = mk(OP_MULT, 16'hFFFF, 16'h0002, 1'b0);
    r.signed_op = 1'b1;
    run(r);
    chk("muls", 32'hFFFF_FFFE, rsp.muldiv);
    r        = mk(OP_DIV_SHORT, 16'h0007, 16'h0007, 1'b0);
    r.muldiv = 32'h0000_0064;
    run(r);
    chk("divu", 32'h0002_000E, rsp.muldiv);
    chk("divu wr", 32'h1, 32'(rsp.wr_muldiv));
    r           = mk(OP_DIV_SHORT, 16'h0002, 16'h0002, 1'b0);
    r.muldiv    = 32'h0000_FFF9;
    r.signed_op = 1'b1;
    run(r);
    chk("divs", 32'hFFFF_FFFD, rsp.muldiv);
    r        = mk(OP_DIV_LONG, 16'h0003, 16'h0003, 1'b0);
    r.muldiv = 32'h0001_0000;
    run(r);
    chk("divl", 32'h0001_5555, rsp.muldiv);
    r.opb = 16'h0001;
    run(r);
    chk("divl ovf wr", 32'h0, 32'(rsp.wr_muldiv));
    chk("divl ovf md", 32'h0001_0000, rsp.muldiv);
    r.opb       = 16'h0002;
    r.muldiv    = 32'hFFFF_FFF9;
    r.signed_op = 1'b1;
    run(r);
    chk("divls", 32'hFFFF_FFFD, rsp.muldiv);
    r        = mk(OP_DIV_LONG, 16'h0000, 16'h0000, 1'b0);
    r.muldiv = 32'h0001_0000;
    run(r);
    chk("div zero wr", 32'h0, 32'(rsp.wr_muldiv));
    chk("div zero v", 32'h1, 32'(rsp.v));
    $display("test muldiv done");
  endtask : t_muldiv

  task automatic t_cmp;
    run(mk(OP_CMP_DEC, 16'h0010, 16'h0010, 1'b1));
    chk("cmpd2 dst", 32'h0000_000E, 32'(rsp.dst));
    chk("cmpd2 z", 32'h1, 32'(rsp.z));
    run(mk(OP_CMP_DEC, 16'h0010, 16'h0001, 1'b0));
    chk("cmpd1 dst", 32'h0000_000F, 32'(rsp.dst));
    run(mk(OP_CMP_INC, 16'h0003, 16'h0005, 1'b0));
    chk("cmpi1 dst", 32'h0000_0004, 32'(rsp.dst));
    chk("cmpi1 c", 32'h1, 32'(rsp.c));
    chk("cmpi1 z", 32'h0, 32'(rsp.z));
    run(mk(OP_CMP_INC, 16'hFFFF, 16'h0000, 1'b1));
    chk("cmpi2 dst", 32'h0000_0001, 32'(rsp.dst));
    $display("test cmp done");
  endtask : t_cmp

  task automatic t_shift;
    run(mk(OP_NORM, 16'h0100, 16'h0000, 1'b0));
    chk("norm", 32'h0000_0007, 32'(rsp.dst));
    run(mk(OP_NORM, 16'h0001, 16'h0000, 1'b0));
    chk("norm low", 32'h0000_000F, 32'(rsp.dst));
    run(mk(OP_SHIFT_ARITH, 16'h8010, 16'h0004, 1'b0));
    chk("arith_shift_right", 32'h0000_F801, 32'(rsp.dst));
    run(mk(OP_ROTATE, 16'h8001, 16'h0001, 1'b1));
    chk("rol", 32'h0000_0003, 32'(rsp.dst));
    run(mk(OP_ROTATE, 16'h8001, 16'h0001, 1'b0));
    chk("ror", 32'h0000_C000, 32'(rsp.dst));
    chk("ror len", 32'(LEN_SHORT), 32'(rsp.len));
    $display("test shift done");
  endtask : t_shift

  task automatic t_unary;
    run(mk(OP_BYTE_EXT, 16'h0080, 16'h0000, 1'b1));
    chk("ext sign", 32'h0000_FF80, 32'(rsp.dst));
    run(mk(OP_BYTE_EXT, 16'h0080, 16'h0000, 1'b0));
    chk("ext zero", 32'h0000_0080, 32'(rsp.dst));
    run(mk(OP_COMPLEMENT, 16'h1234, 16'h0000, 1'b0));
    chk("cpl", 32'h0000_EDCB, 32'(rsp.dst));
    r         = mk(OP_COMPLEMENT, 16'h0012, 16'h0000, 1'b0);
    r.byte_op = 1'b1;
    r.hi_byte = 1'b1;
    r.dst_old = 16'h34CD;
    run(r);
    chk("cplb", 32'h0000_EDCD, 32'(rsp.dst));
    run(mk(OP_NEGATE, 16'h0001, 16'h0000, 1'b0));
    chk("neg", 32'h0000_FFFF, 32'(rsp.dst));
    r         = mk(OP_NEGATE, 16'h0001, 16'h0000, 1'b0);
    r.byte_op = 1'b1;
    r.dst_old = 16'hAB00;
    run(r);
    chk("negb", 32'h0000_ABFF, 32'(rsp.dst));
    r         = mk(OP_MASK_MOD, 16'h00F0, 16'h153C, 1'b0);
    r.dst_old = 16'h1200;
    run(r);
    chk("mask mod", 32'h0000_12D4, 32'(rsp.dst));
    chk("mask len", 32'(LEN_LONG), 32'(rsp.len));
    $display("test unary done");
  endtask : t_unary

  task automatic t_bits;
    r       = mk(OP_BIT_COPY, 16'h0000, 16'h0000, 1'b1);
    r.bit_a = 1'b1;
    run(r);
    chk("bmov inv", 32'h0, 32'(rsp.bit_val));
    chk("bmov wr", 32'h1, 32'(rsp.wr_bit));
    r.variant = 1'b0;
    run(r);
    chk("bmov", 32'h1, 32'(rsp.bit_val));
    for (k = 0; k < 3; k++) begin
      r        = mk(OP_BIT_LOGIC, 16'h0000, 16'h0000, 1'b0);
      r.bit_a  = 1'b1;
      r.bit_op = cis_bitop_type'(k);
      run(r);
      chk("bit logic", (k != 0) ? 32'h1 : 32'h0, 32'(rsp.bit_val));
    end
    r         = mk(OP_JUMP_SET, 16'h0000, 16'h0000, 1'b1);
    r.bit_a   = 1'b1;
    r.pc_next = 16'h0100;
    r.rel_off = 16'h0010;
    run(r);
    chk("jbc pc", 32'h0001_0110, {15'h0, rsp.jump, rsp.jump_pc});
    chk("jbc bit", 32'h2, {30'h0, rsp.wr_bit, rsp.bit_val});
    r.op = OP_JUMP_CLR;
    run(r);
    chk("jnbs not taken", 32'h0, {30'h0, rsp.jump, rsp.wr_bit});
    r.bit_a = 1'b0;
    run(r);
    chk("jnbs bit", 32'h7, {29'h0, rsp.jump, rsp.wr_bit, rsp.bit_val});
    $display("test bits done");
  endtask : t_bits

  task automatic t_stack;
    r         = mk(OP_PUSH_CALL, 16'h5555, 16'h0000, 1'b0);
    r.pc_next = 16'h0200;
    r.target  = 16'h4000;
    run(r);
    chk("push_and_call push", 32'h5555_0200, {rsp.push0, rsp.push1});
    chk("push_and_call jump", 32'h0002_4000, {14'h0, rsp.push_cnt, rsp.jump_pc});
    r         = mk(OP_CTX_SWITCH, 16'h0000, 16'h2222, 1'b0);
    r.dst_old = 16'h1111;
    run(r);
    chk("context_switch", 32'h1111_2222, {rsp.push0, rsp.dst});
    chk("context_switch cnt", 32'h1, 32'(rsp.push_cnt));
    r        = mk(OP_RETURN, 16'h0000, 16'h0000, 1'b1);
    r.stack0 = 16'h0300;
    r.stack1 = 16'h7777;
    run(r);
    chk("retp", 32'h0300_7777, {rsp.jump_pc, rsp.dst});
    chk("retp cnt", 32'h2, 32'(rsp.pop_cnt));
    r.variant = 1'b0;
    run(r);
    chk("ret", 32'h0001_0300, {15'h0, rsp.jump, rsp.jump_pc});
    chk("ret wr", 32'h0, 32'(rsp.wr_dst));
    r.valid = 1'b0;
    run(r);
    chk("idle", 32'h0, {29'h0, rsp.jump, rsp.wr_dst, rsp.valid});
    $display("test stack done");
  endtask : t_stack

  task automatic t_power;
    I_NMI_PIN = 1'b1;
    repeat (3) @(negedge I_SYS_CLK);
    run(mk(OP_POWER_DOWN, 16'h0000, 16'h0000, 1'b0));
    chk("power_down_instr pin high", 32'h0, 32'(O_POWER_DOWN));
    I_NMI_PIN = 1'b0;
    I_REQ     = '0;
    repeat (3) @(negedge I_SYS_CLK);
    chk("power_down_instr idle", 32'h0, 32'(O_POWER_DOWN));
    run(mk(OP_POWER_DOWN, 16'h0000, 16'h0000, 1'b0));
    chk("power_down_instr", 32'h1, 32'(O_POWER_DOWN));
    I_REQ = '0;
    repeat (4) @(negedge I_SYS_CLK);
    chk("power_down_instr sticky", 32'h1, 32'(O_POWER_DOWN));
    I_ARST_N = 1'b0;
    @(negedge I_SYS_CLK);
    chk("power_down_instr reset", 32'h0, 32'(O_POWER_DOWN));
    chk("rsp reset", 32'h0, 32'(O_RSP.valid));
    I_ARST_N = 1'b1;
    @(negedge I_SYS_CLK);
    $display("test power done");
  endtask : t_power

  initial begin
    fails     = 0;
    tests_run = 0;
    I_ARST_N  = 1'b0;
    I_REQ     = '0;
    I_NMI_PIN = 1'b0;
    repeat (12) @(posedge I_SYS_CLK);
    @(negedge I_SYS_CLK);
    I_ARST_N = 1'b1;
    t_addsub();
    t_muldiv();
    t_cmp();
    t_shift();
    t_unary();
    t_bits();
    t_stack();
    t_power();
    wrap_up();
  end

  initial begin
    for (int n = 0; n < 20000; n++) begin
      @(posedge I_SYS_CLK);
    end
    fails++;
    wrap_up();
  end
endmodule : tb
